// ---- core/bpra_pkg.sv ----
package bpra_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int HDR_WRITE = 5;
  localparam int HDR_FROM_TABLE = 4;
  localparam int HDR_AUTO_INC = 3;
  localparam int HDR_ADDR_SIZE = 2;
  localparam logic [1:0] TYPE_DATA = 2'b01;
  localparam logic [1:0] TYPE_PROC = 2'b10;
  localparam logic [1:0] TYPE_LOCAL = 2'b11;
  localparam logic [7:0] RD_UNIT_ADDR = 8'hc0;
  localparam logic [7:0] RD_STATUS = 8'hc1;
  localparam logic [7:0] RD_PMEM = 8'hca;
  localparam logic [7:0] RD_TIMEOUT = 8'hcb;
  localparam logic [7:0] RD_ADDR_LO = 8'hd8;
  localparam logic [7:0] RD_ADDR_HI = 8'hd9;
  localparam logic [7:0] RD_PITCH = 8'hdc;
  localparam logic [7:0] RD_SIZE_LO = 8'hdd;
  localparam logic [7:0] RD_SIZE_HI = 8'hde;
  localparam logic [7:0] RD_COOKIE = 8'hdf;
  localparam logic [7:0] WR_STATUS = 8'he1;
  localparam logic [7:0] WR_PMEM = 8'hea;
  localparam logic [7:0] WR_TIMEOUT = 8'heb;
  localparam logic [7:0] WR_ADDR_LO = 8'hf8;
  localparam logic [7:0] WR_ADDR_HI = 8'hf9;
  localparam logic [7:0] WR_ADDR_ADD = 8'hfa;
  localparam logic [7:0] WR_PROC_RESET = 8'hfe;
  localparam logic [7:0] WR_PARSER_RESET = 8'hff;
  localparam logic [7:0] COOKIE = 8'h5a;
  localparam logic [7:0] RESET_KEY = 8'h5a;
  // unit address value is arbitrary
  localparam logic [7:0] UNIT_ADDRESS = 8'h01;
  localparam int ST_TIMEOUT = 6;
  localparam int ST_BAD_WRITE = 5;
  localparam int ST_OVERFLOW = 4;
  localparam int ST_WATCHDOG = 3;
  localparam logic [7:0] STATUS_MASK = 8'h78;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] TIMEOUT_RST = 8'h00;
  localparam logic [7:0] PROC_PITCH = 8'h08;
  localparam int TABLE_AW = 9;
  localparam int TABLE_SIZE = 512;
  localparam logic [15:0] TABLE_SIZE_W = 16'h0200;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;

  typedef enum logic [3:0] {
    S_HDR, S_ALO, S_AHI, S_WDATA, S_RREQ, S_RWAIT, S_SEND, S_LOP, S_CHK, S_CRC
  } bpra_state_e;

  function automatic logic [7:0] bpra_crc_byte(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction : bpra_crc_byte
endpackage : bpra_pkg

// ---- core/bpra_stream_if.sv ----
`timescale 1ns/1ps
interface bpra_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface : bpra_stream_if

// ---- core/bpra_fifo.sv ----
`timescale 1ns/1ps
module bpra_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  bpra_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic ready_q;
  logic push;
  logic pop;

  assign push = in_valid && ready_q;
  assign pop = out.valid && out.ready;
  assign out.valid = (cnt_q != '0);
  assign out.data = mem_q[rp_q];
  assign in_ready = ready_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (!push && pop) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (push && wp_q == AW'(i)) begin
        mem_q[i] <= in_data;
      end
    end
  end
endmodule : bpra_fifo

// ---- core/bpra_core.sv ----
// How it works
// - host sends header, device answers as slave
// - top bits 01 mean data command
// - header bit five chooses write or read
// - in a procedure, bit four takes write data from table
// - bit three advances pointer by size
// - bit two adds two address bytes
// - low bits give one, two, four, eight bytes
// - multi byte uses consecutive addresses
// - local read codes return one byte
// - code c1 returns the status flags
// - code df returns fixed cookie 5a
// - local writes other than ff take one operand byte
// - code e1 loads status, zero clears
// - ea sets, ca reads procedure memory flag
// - eb sets, cb reads command timeout
// - f8 f9 fa d8 d9 handle pointer
// - fe resets processor only with 5a
// - ff resets parser at once
// - top bits 10 run stored procedure
// - procedure n starts at n times eight
// - procedure runs entries until a header byte whose top bits are not 01
// - characters carry eight bits, no parity
// - serial commands and answers carry check
`timescale 1ns/1ps
module bpra_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic crc_mode,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data_q,
  output logic tx_valid_q,
  input wire logic tx_ready,
  output logic [15:0] reg_addr_q,
  output logic [7:0] reg_wdata_q,
  output logic reg_we_q,
  output logic reg_re_q,
  input wire logic [7:0] reg_rdata,
  input wire logic timeout_evt,
  input wire logic bad_write_evt,
  input wire logic watchdog_evt,
  output logic [7:0] status_q,
  output logic [15:0] addr_q,
  output logic pmem_q,
  output logic [7:0] timeout_q
);
  bpra_stream_if rx_s();
  bpra_pkg::bpra_state_e state_q;
  bpra_pkg::bpra_state_e end_st;
  logic [7:0] hdr_q;
  logic [15:0] wa_q;
  logic [2:0] cnt_q;
  logic in_proc_q;
  logic [bpra_pkg::TABLE_AW-1:0] tp_q;
  logic [7:0] rd_q;
  logic [7:0] crc_q;
  logic [7:0] table_q [bpra_pkg::TABLE_SIZE];
  logic use_tab;
  logic src_valid;
  logic [7:0] src_byte;
  logic take;
  logic hdr_take;
  logic lop_take;
  logic wr_take;
  logic send_go;
  logic kreset;
  logic clr;
  logic tab_we;
  logic [7:0] lr_val;
  logic [15:0] len16;
  logic [7:0] evt;

  bpra_fifo #(
    .WIDTH(bpra_pkg::BYTE_W),
    .DEPTH(bpra_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out(rx_s)
  );

  assign use_tab = in_proc_q && (state_q != bpra_pkg::S_WDATA || hdr_q[bpra_pkg::HDR_FROM_TABLE]);
  assign src_valid = use_tab ? 1'b1 : rx_s.valid;
  assign src_byte = use_tab ? table_q[tp_q] : rx_s.data;
  assign take = src_valid && (state_q == bpra_pkg::S_HDR || state_q == bpra_pkg::S_ALO ||
                state_q == bpra_pkg::S_AHI || state_q == bpra_pkg::S_WDATA ||
                state_q == bpra_pkg::S_LOP || state_q == bpra_pkg::S_CHK);
  assign rx_s.ready = take && !use_tab;
  assign hdr_take = src_valid && state_q == bpra_pkg::S_HDR;
  assign lop_take = src_valid && state_q == bpra_pkg::S_LOP;
  assign wr_take = src_valid && state_q == bpra_pkg::S_WDATA;
  assign send_go = !tx_valid_q && state_q == bpra_pkg::S_SEND;
  assign kreset = lop_take && hdr_q == bpra_pkg::WR_PROC_RESET && src_byte == bpra_pkg::RESET_KEY;
  assign clr = rst || kreset;
  assign tab_we = wr_take && pmem_q;
  assign len16 = 16'h0001 << hdr_q[1:0];
  // wait for check byte on serial
  assign end_st = crc_mode ? bpra_pkg::S_CHK : bpra_pkg::S_HDR;
  assign evt = {1'b0, timeout_evt, bad_write_evt, !rx_ready && rx_valid, watchdog_evt, 3'b000};

  always_comb begin
    lr_val = 8'h00;
    case (src_byte)
      bpra_pkg::RD_UNIT_ADDR: lr_val = bpra_pkg::UNIT_ADDRESS;
      bpra_pkg::RD_STATUS: lr_val = status_q;
      bpra_pkg::RD_PMEM: lr_val = {7'b0000000, pmem_q};
      bpra_pkg::RD_TIMEOUT: lr_val = timeout_q;
      bpra_pkg::RD_ADDR_LO: lr_val = addr_q[7:0];
      bpra_pkg::RD_ADDR_HI: lr_val = addr_q[15:8];
      bpra_pkg::RD_PITCH: lr_val = bpra_pkg::PROC_PITCH;
      bpra_pkg::RD_SIZE_LO: lr_val = bpra_pkg::TABLE_SIZE_W[7:0];
      bpra_pkg::RD_SIZE_HI: lr_val = bpra_pkg::TABLE_SIZE_W[15:8];
      bpra_pkg::RD_COOKIE: lr_val = bpra_pkg::COOKIE;
      default: lr_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      state_q <= bpra_pkg::S_HDR;
      hdr_q <= 8'h00;
      addr_q <= 16'h0000;
      wa_q <= 16'h0000;
      cnt_q <= 3'h0;
      in_proc_q <= 1'b0;
      tp_q <= '0;
      rd_q <= 8'h00;
    end else begin
      if (take && use_tab) begin
        tp_q <= tp_q + 1'b1;
      end
      unique case (state_q)
        bpra_pkg::S_HDR: begin
          if (src_valid) begin
            hdr_q <= src_byte;
            if (in_proc_q && src_byte[7:6] != bpra_pkg::TYPE_DATA) begin
              in_proc_q <= 1'b0;
              state_q <= end_st;
            end else if (src_byte[7:6] == bpra_pkg::TYPE_DATA) begin
              cnt_q <= 3'((4'h1 << src_byte[1:0]) - 4'h1);
              wa_q <= addr_q;
              if (src_byte[bpra_pkg::HDR_ADDR_SIZE]) begin
                state_q <= bpra_pkg::S_ALO;
              end else if (src_byte[bpra_pkg::HDR_WRITE]) begin
                state_q <= bpra_pkg::S_WDATA;
              end else begin
                state_q <= bpra_pkg::S_RREQ;
              end
            end else if (src_byte[7:6] == bpra_pkg::TYPE_PROC) begin
              in_proc_q <= 1'b1;
              tp_q <= {src_byte[5:0], 3'b000};
            end else if (src_byte[7:6] == bpra_pkg::TYPE_LOCAL) begin
              if (src_byte == bpra_pkg::WR_PARSER_RESET) begin
                state_q <= bpra_pkg::S_HDR;
              end else if (src_byte[5]) begin
                state_q <= bpra_pkg::S_LOP;
              end else begin
                rd_q <= lr_val;
                cnt_q <= 3'h0;
                state_q <= bpra_pkg::S_SEND;
              end
            end
          end
        end
        bpra_pkg::S_ALO: begin
          if (src_valid) begin
            wa_q[7:0] <= src_byte;
            state_q <= bpra_pkg::S_AHI;
          end
        end
        bpra_pkg::S_AHI: begin
          if (src_valid) begin
            wa_q[15:8] <= src_byte;
            addr_q <= {src_byte, wa_q[7:0]};
            // write or read by bit five
            state_q <= hdr_q[bpra_pkg::HDR_WRITE] ? bpra_pkg::S_WDATA : bpra_pkg::S_RREQ;
          end
        end
        bpra_pkg::S_WDATA: begin
          if (src_valid) begin
            if (cnt_q == 3'h0) begin
              if (hdr_q[bpra_pkg::HDR_AUTO_INC]) begin
                addr_q <= addr_q + len16;
              end
              state_q <= in_proc_q ? bpra_pkg::S_HDR : end_st;
            end else begin
              cnt_q <= cnt_q - 3'h1;
              wa_q <= wa_q + 16'h0001;
            end
          end
        end
        bpra_pkg::S_RREQ: begin
          if (pmem_q) begin
            rd_q <= table_q[wa_q[bpra_pkg::TABLE_AW-1:0]];
            state_q <= bpra_pkg::S_SEND;
          end else begin
            state_q <= bpra_pkg::S_RWAIT;
          end
        end
        bpra_pkg::S_RWAIT: begin
          rd_q <= reg_rdata;
          state_q <= bpra_pkg::S_SEND;
        end
        bpra_pkg::S_SEND: begin
          if (!tx_valid_q) begin
            if (cnt_q == 3'h0) begin
              if (hdr_q[7:6] == bpra_pkg::TYPE_DATA && hdr_q[bpra_pkg::HDR_AUTO_INC]) begin
                addr_q <= addr_q + len16;
              end
              state_q <= in_proc_q ? bpra_pkg::S_HDR : end_st;
            end else begin
              cnt_q <= cnt_q - 3'h1;
              wa_q <= wa_q + 16'h0001;
              state_q <= bpra_pkg::S_RREQ;
            end
          end
        end
        bpra_pkg::S_LOP: begin
          if (src_valid) begin
            if (hdr_q == bpra_pkg::WR_ADDR_LO) begin
              addr_q[7:0] <= src_byte;
            end else if (hdr_q == bpra_pkg::WR_ADDR_HI) begin
              addr_q[15:8] <= src_byte;
            end else if (hdr_q == bpra_pkg::WR_ADDR_ADD) begin
              addr_q <= addr_q + {8'h00, src_byte};
            end
            state_q <= end_st;
          end
        end
        bpra_pkg::S_CHK: begin
          if (src_valid) begin
            state_q <= bpra_pkg::S_CRC;
          end
        end
        bpra_pkg::S_CRC: begin
          if (!tx_valid_q) begin
            state_q <= bpra_pkg::S_HDR;
          end
        end
      endcase
    end
  end

  // answer byte and running check byte
  always_ff @(posedge clk) begin
    if (clr) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      crc_q <= 8'h00;
    end else begin
      if (tx_valid_q && tx_ready) begin
        tx_valid_q <= 1'b0;
      end
      if (send_go) begin
        tx_valid_q <= 1'b1;
        tx_data_q <= rd_q;
        crc_q <= crc_mode ? bpra_pkg::bpra_crc_byte(crc_q, rd_q) : 8'h00;
      end
      if (state_q == bpra_pkg::S_CRC && !tx_valid_q) begin
        tx_valid_q <= 1'b1;
        tx_data_q <= crc_q;
        crc_q <= 8'h00;
      end
      if (hdr_take && !in_proc_q && src_byte == bpra_pkg::WR_PARSER_RESET) begin
        crc_q <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      status_q <= bpra_pkg::STATUS_RST;
    end else if (lop_take && hdr_q == bpra_pkg::WR_STATUS) begin
      status_q <= (src_byte & bpra_pkg::STATUS_MASK) | evt;
    end else begin
      status_q <= status_q | evt;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      pmem_q <= 1'b0;
      timeout_q <= bpra_pkg::TIMEOUT_RST;
    end else if (lop_take) begin
      if (hdr_q == bpra_pkg::WR_PMEM) begin
        pmem_q <= (src_byte != 8'h00);
      end
      if (hdr_q == bpra_pkg::WR_TIMEOUT) begin
        timeout_q <= src_byte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      reg_we_q <= 1'b0;
      reg_re_q <= 1'b0;
      reg_addr_q <= 16'h0000;
      reg_wdata_q <= 8'h00;
    end else begin
      reg_we_q <= wr_take && !pmem_q;
      reg_re_q <= state_q == bpra_pkg::S_RREQ && !pmem_q;
      if (wr_take || state_q == bpra_pkg::S_RREQ) begin
        reg_addr_q <= wa_q;
      end
      if (wr_take) begin
        reg_wdata_q <= src_byte;
      end
    end
  end

  for (genvar i = 0; i < bpra_pkg::TABLE_SIZE; i++) begin : g_table
    always_ff @(posedge clk) begin
      if (tab_we && wa_q[bpra_pkg::TABLE_AW-1:0] == bpra_pkg::TABLE_AW'(i)) begin
        table_q[i] <= src_byte;
      end
    end
  end

  a_cookie_reply: assert property (@(posedge clk) disable iff (rst)
    hdr_take && !in_proc_q && src_byte == bpra_pkg::RD_COOKIE |-> ##[1:3] tx_valid_q && tx_data_q == 8'h5a)
    else $error("cookie not answered");
  a_status_reply: assert property (@(posedge clk) disable iff (rst)
    hdr_take && !in_proc_q && src_byte == bpra_pkg::RD_STATUS && !tx_valid_q
    |-> ##2 tx_valid_q && tx_data_q == $past(status_q, 2))
    else $error("status byte not answered");
  a_parser_reset: assert property (@(posedge clk) disable iff (rst)
    hdr_take && !in_proc_q && src_byte == 8'hff |=> state_q == bpra_pkg::S_HDR && !in_proc_q)
    else $error("parser reset not immediate");
  a_write_strobe: assert property (@(posedge clk) disable iff (rst)
    wr_take && !pmem_q && !kreset |=> reg_we_q && reg_wdata_q == $past(src_byte) && reg_addr_q == $past(wa_q))
    else $error("write byte not strobed");
  a_read_strobe: assert property (@(posedge clk) disable iff (rst)
    state_q == bpra_pkg::S_RREQ && !pmem_q |=> reg_re_q && reg_addr_q == $past(wa_q) ##1 state_q == bpra_pkg::S_SEND)
    else $error("read request wrong");
  a_auto_inc: assert property (@(posedge clk) disable iff (rst)
    wr_take && cnt_q == 3'h0 && hdr_q[3] |=> addr_q == $past(addr_q) + $past(len16))
    else $error("pointer not advanced");
  a_no_inc: assert property (@(posedge clk) disable iff (rst)
    wr_take && cnt_q == 3'h0 && !hdr_q[3] |=> addr_q == $past(addr_q))
    else $error("pointer moved without auto bit");
  a_proc_start: assert property (@(posedge clk) disable iff (rst)
    hdr_take && !in_proc_q && src_byte[7:6] == 2'b10 |=> in_proc_q && tp_q == {$past(src_byte[5:0]), 3'b000})
    else $error("procedure start wrong");
  a_key_reset: assert property (@(posedge clk) disable iff (rst)
    lop_take && hdr_q == 8'hfe && src_byte != 8'h5a |=> state_q == end_st && $stable(pmem_q))
    else $error("processor reset without key");
  a_status_clear: assert property (@(posedge clk) disable iff (rst)
    lop_take && hdr_q == 8'he1 && src_byte == 8'h00 && evt == 8'h00 |=> status_q == 8'h00)
    else $error("status not cleared");
  c_proc_run: cover property (@(posedge clk) disable iff (rst) in_proc_q && hdr_take && src_byte == 8'h00);
  c_read_eight: cover property (@(posedge clk) disable iff (rst) send_go && hdr_q[1:0] == 2'b11 && cnt_q == 3'h0);
  c_key_reset: cover property (@(posedge clk) disable iff (rst) kreset);
  c_crc_sent: cover property (@(posedge clk) disable iff (rst) state_q == bpra_pkg::S_CRC && !tx_valid_q);
endmodule : bpra_core

// ---- sim/bpra_host.sv ----
`timescale 1ns/1ps
module bpra_host (
  input wire logic clk,
  input wire logic rst,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data_q,
  input wire logic tx_valid_q,
  output logic tx_ready
);
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [7:0] got[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  task automatic send(input logic [7:0] b[$], input int lim, output bit ok);
    int n;
    ok = 1'b1;
    foreach (b[i]) begin
      if (ok) begin
        rx_data = b[i];
        rx_valid = 1'b1;
        n = 0;
        while (rx_ready !== 1'b1 && n < lim) begin
          @(posedge clk);
          #1;
          n++;
        end
        if (n == lim) begin
          ok = 1'b0;
        end else begin
          @(posedge clk);
          #1;
        end
      end
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    @(posedge clk);
    #1;
  endtask : send
  // answers collected, ready can stall or alternate
  always @(posedge clk) begin
    if (tx_valid_q === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data_q);
    tx_ready <= #1 !stall && !(slow && tx_ready);
  end
endmodule : bpra_host

// ---- sim/byte_protocol_register_access_tb.sv ----
`timescale 1ns/1ps
module byte_protocol_register_access_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic crc_mode = 1'b0;
  logic [7:0] rx_data, tx_data_q, reg_wdata_q, status_q, timeout_q;
  logic rx_valid, rx_ready, tx_valid_q, tx_ready, reg_we_q, reg_re_q, pmem_q;
  logic [7:0] reg_rdata;
  logic [15:0] reg_addr_q, addr_q;
  logic timeout_evt = 1'b0;
  logic bad_write_evt = 1'b0;
  logic watchdog_evt = 1'b0;
  logic [7:0] mem [0:255];
  int n_fail = 0;
  int tests_run = 0;

  always #10 clk = ~clk;

  bpra_core i_dut (.clk(clk), .rst(rst), .crc_mode(crc_mode), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .reg_addr_q(reg_addr_q), .reg_wdata_q(reg_wdata_q), .reg_we_q(reg_we_q), .reg_re_q(reg_re_q),
    .reg_rdata(reg_rdata), .timeout_evt(timeout_evt), .bad_write_evt(bad_write_evt),
    .watchdog_evt(watchdog_evt), .status_q(status_q), .addr_q(addr_q), .pmem_q(pmem_q), .timeout_q(timeout_q));
  bpra_host i_host (.clk(clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready));

  // register space, read data stands while the read strobe is high
  always @(posedge clk) begin
    if (reg_we_q === 1'b1) mem[reg_addr_q[7:0]] <= reg_wdata_q;
  end
  always_comb reg_rdata = (reg_re_q === 1'b1) ? mem[reg_addr_q[7:0]] : ~mem[reg_addr_q[7:0]];

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    repeat (8) c = c[0] ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction : crc8

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic put(input logic [7:0] b[$]);
    bit ok;
    i_host.send(b, 100, ok);
    if (!ok) begin
      n_fail++;
      end_sim;
    end
  endtask : put

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic expect_bytes(input string what, input logic [7:0] e[$]);
    int n;
    foreach (e[i]) begin
      n = 0;
      while (i_host.got.size() == 0 && n < 300) begin
        idle(1);
        n++;
      end
      if (n == 300) begin
        n_fail++;
        end_sim;
      end
      chk(what, e[i], i_host.got.pop_front());
    end
    idle(12);
    chk("extra answer bytes", 16'h0000, 16'(i_host.got.size()));
  endtask : expect_bytes

  task automatic sc_local_reads;
    put('{8'hdf, 8'hdc, 8'hdd, 8'hde, 8'hc0});
    expect_bytes("local reads", '{8'h5a, 8'h08, 8'h00, 8'h02, bpra_pkg::UNIT_ADDRESS});
  endtask : sc_local_reads

  task automatic sc_pointer;
    put('{8'hf8, 8'hfd, 8'hf9, 8'h12, 8'hd8, 8'hd9, 8'hfa, 8'h05});
    expect_bytes("pointer bytes", '{8'hfd, 8'h12});
    chk("pointer after add", 16'h1302, addr_q);
  endtask : sc_pointer

  task automatic sc_data;
    put('{8'h6e, 8'h00, 8'h00, 8'haa, 8'hbb, 8'hcc, 8'h00});
    idle(12);
    chk("write bytes", 16'hbbaa, {mem[1], mem[0]});
    chk("write bytes high", 16'h00cc, {mem[3], mem[2]});
    chk("pointer auto inc", 16'h0004, addr_q);
    put('{8'h42});
    expect_bytes("pointer read", '{8'h38, 8'h39, 8'h3a, 8'h3b});
    chk("pointer kept", 16'h0004, addr_q);
    put('{8'h4d, 8'h01, 8'h00});
    expect_bytes("addressed read", '{8'hbb, 8'hcc});
    chk("pointer plus two", 16'h0003, addr_q);
    put('{8'h67, 8'h10, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    put('{8'h40});
    expect_bytes("one byte read", '{8'h01});
    chk("eight byte write", 16'h0807, {mem[8'h17], mem[8'h16]});
  endtask : sc_data

  task automatic sc_status;
    timeout_evt = 1'b1;
    bad_write_evt = 1'b1;
    watchdog_evt = 1'b1;
    idle(1);
    timeout_evt = 1'b0;
    bad_write_evt = 1'b0;
    watchdog_evt = 1'b0;
    put('{8'hc1});
    expect_bytes("status", '{8'h68});
    put('{8'he1, 8'h00});
    idle(8);
    chk("status cleared", 16'h0000, status_q);
  endtask : sc_status

  task automatic sc_flags;
    put('{8'hea, 8'h02, 8'heb, 8'h07, 8'hca, 8'hcb});
    expect_bytes("flag and timeout", '{8'h01, 8'h07});
    chk("timeout setting", 16'h0007, timeout_q);
    put('{8'hea, 8'h00});
    idle(8);
    chk("table flag off", 16'h0000, pmem_q);
  endtask : sc_flags

  task automatic sc_proc;
    put('{8'hea, 8'h01});
    put('{8'h67, 8'h28, 8'h00, 8'h45, 8'h08, 8'h00, 8'h74, 8'h0c, 8'h00, 8'h99, 8'h00});
    put('{8'hea, 8'h00});
    put('{8'h85});
    expect_bytes("procedure read", '{8'h34, 8'h35});
    chk("procedure table write", 16'h0099, mem[8'h0c]);
  endtask : sc_proc

  task automatic sc_serial;
    crc_mode = 1'b1;
    put('{8'hdf, crc8(8'h00, 8'hdf)});
    expect_bytes("checked cookie", '{8'h5a, crc8(8'h00, 8'h5a)});
    put('{8'he1, 8'h00, crc8(crc8(8'h00, 8'he1), 8'h00)});
    expect_bytes("empty check", '{8'h00});
    crc_mode = 1'b0;
  endtask : sc_serial

  task automatic sc_fill;
    int n;
    bit ok;
    logic [7:0] e[$];
    n = 0;
    ok = 1'b1;
    i_host.stall = 1'b1;
    while (ok && n < 40) begin
      i_host.send('{8'hdf}, 4, ok);
      if (ok) n++;
    end
    chk("fifo refused", 16'h0000, rx_ready);
    chk("fifo filled", 16'h0001, 16'(n >= 32 && n <= 34));
    i_host.stall = 1'b0;
    i_host.slow = 1'b1;
    repeat (n) e.push_back(8'h5a);
    expect_bytes("drained answers", e);
    put('{8'hc1});
    expect_bytes("overflow flag", '{8'h10});
    i_host.slow = 1'b0;
    put('{8'he1, 8'h00});
  endtask : sc_fill

  task automatic sc_resets;
    put('{8'hf8, 8'h44, 8'hfe, 8'h00});
    idle(8);
    chk("wrong key kept", 16'h0044, addr_q);
    put('{8'hea, 8'h01, 8'hfe, 8'h5a});
    idle(8);
    chk("key reset pointer", 16'h0000, addr_q);
    chk("key reset flag", 16'h0000, pmem_q);
    put('{8'hff, 8'hdf});
    expect_bytes("parser reset", '{8'h5a});
  endtask : sc_resets

  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h3c;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    idle(2);
    sc_local_reads;
    sc_pointer;
    sc_data;
    sc_status;
    sc_flags;
    sc_proc;
    sc_serial;
    sc_fill;
    sc_resets;
    end_sim;
  end
endmodule : byte_protocol_register_access_tb
